// ---- dual_data_pointer_unit.sv ----
// dual data pointer unit: two background pointers behind one active pointer
`timescale 1ns/1ps
module dual_data_pointer_unit (
  // clock and reset
  input  wire logic                 mclk_i,
  input  wire logic                 rst_i,
  // special-function bus from the core
  input  wire active_data_pointer_pkg::sfr_req_type sfr_req_i,
  output logic      [7:0]           sfr_rdata_o,
  output logic                      sfr_hit_o,
  // external-data move done, using the active pointer
  input  wire logic                 ext_move_done_i,
  // active pointer as external-data address
  output logic      [15:0]          active_data_pointer_o,
  // select bit as the core sees it
  output logic                      pointer_select_o
);
  logic                    pointer_select;
  logic                    auto_toggle;
  logic [3:0]              mode_bits;
  logic [15:0]             background_pointer_zero;
  logic [15:0]             background_pointer_one;
  logic                    wr_low;
  logic                    wr_high;
  logic                    wr_ctrl;
  logic                    wr_mode;
  active_data_pointer_pkg::step_mode_type pointer_zero_step_mode;
  active_data_pointer_pkg::step_mode_type pointer_one_step_mode;
  logic                    hit_low;
  logic                    hit_high;
  logic                    hit_ctrl;
  logic                    hit_mode;
  logic                    rd_low;
  logic                    rd_high;
  logic                    rd_ctrl;
  logic                    rd_mode;
  logic                    toggle_now;
  logic                    next_pointer_select;
  logic                    next_auto_toggle;
  logic                    load_zero_low;
  logic                    load_zero_high;
  logic                    load_one_low;
  logic                    load_one_high;
  logic                    step_zero;
  logic                    step_one;
  logic [7:0]              ctrl_view;
  logic [7:0]              mode_view;
  logic [7:0]              next_rdata;
  logic                    next_hit;

  // address match, shared by reads and writes
  assign hit_low  = (sfr_req_i.addr == active_data_pointer_pkg::ADDR_PTR_LOW);
  assign hit_high = (sfr_req_i.addr == active_data_pointer_pkg::ADDR_PTR_HIGH);
  assign hit_ctrl = (sfr_req_i.addr == active_data_pointer_pkg::ADDR_CONTROL);
  assign hit_mode = (sfr_req_i.addr == active_data_pointer_pkg::ADDR_MODE);

  // write decode
  assign wr_low  = sfr_req_i.wr && hit_low;
  assign wr_high = sfr_req_i.wr && hit_high;
  assign wr_ctrl = sfr_req_i.wr && hit_ctrl;
  assign wr_mode = sfr_req_i.wr && hit_mode;

  // read decode
  assign rd_low  = sfr_req_i.rd && hit_low;
  assign rd_high = sfr_req_i.rd && hit_high;
  assign rd_ctrl = sfr_req_i.rd && hit_ctrl;
  assign rd_mode = sfr_req_i.rd && hit_mode;

  // mode fields, one per pointer
  assign pointer_zero_step_mode =
    active_data_pointer_pkg::step_mode_type'(mode_bits[active_data_pointer_pkg::ZERO_MODE_LSB +: 2]);
  assign pointer_one_step_mode =
    active_data_pointer_pkg::step_mode_type'(mode_bits[active_data_pointer_pkg::ONE_MODE_LSB +: 2]);

  // a completed external move toggles only while auto toggle is on
  assign toggle_now = ext_move_done_i && auto_toggle;

  // next control bits: a firmware write beats the move toggle
  always_comb begin
    next_pointer_select = pointer_select;
    next_auto_toggle    = auto_toggle;
    if (wr_ctrl) begin
      next_pointer_select = sfr_req_i.wdata[active_data_pointer_pkg::SELECT_BIT];
      next_auto_toggle    = sfr_req_i.wdata[active_data_pointer_pkg::TOGGLE_BIT];
    end else if (toggle_now) begin
      next_pointer_select = ~pointer_select;
    end
  end

  // pointer select bit, cleared by reset
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pointer_select <= active_data_pointer_pkg::CONTROL_RESET[active_data_pointer_pkg::SELECT_BIT];
    end else begin
      pointer_select <= next_pointer_select;
    end
  end

  // auto toggle bit
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      auto_toggle <= active_data_pointer_pkg::CONTROL_RESET[active_data_pointer_pkg::TOGGLE_BIT];
    end else begin
      auto_toggle <= next_auto_toggle;
    end
  end

  // mode register
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      mode_bits <= active_data_pointer_pkg::MODE_RESET[3:0];
    end else if (wr_mode) begin
      mode_bits <= sfr_req_i.wdata[3:0];
    end
  end

  // byte loads reach only the selected pointer
  assign load_zero_low  = wr_low && !pointer_select;
  assign load_zero_high = wr_high && !pointer_select;
  assign load_one_low   = wr_low && pointer_select;
  assign load_one_high  = wr_high && pointer_select;

  // only a completed external move steps, and only the active pointer
  assign step_zero = ext_move_done_i && !pointer_select;
  assign step_one  = ext_move_done_i && pointer_select;

  // pointer zero: reachable and steppable only while selected
  pointer_stepper #(
    .WIDTH (active_data_pointer_pkg::PTR_WIDTH)
  ) u_pointer_zero (
    .mclk_i      (mclk_i),
    .rst_i       (rst_i),
    .load_low_i  (load_zero_low),
    .load_high_i (load_zero_high),
    .load_data_i (sfr_req_i.wdata),
    .step_i      (step_zero),
    .mode_i      (pointer_zero_step_mode),
    .value_o     (background_pointer_zero)
  );

  // pointer one
  pointer_stepper #(
    .WIDTH (active_data_pointer_pkg::PTR_WIDTH)
  ) u_pointer_one (
    .mclk_i      (mclk_i),
    .rst_i       (rst_i),
    .load_low_i  (load_one_low),
    .load_high_i (load_one_high),
    .load_data_i (sfr_req_i.wdata),
    .step_i      (step_one),
    .mode_i      (pointer_one_step_mode),
    .value_o     (background_pointer_one)
  );

  // active pointer mux
  always_comb begin
    if (pointer_select) begin
      active_data_pointer_o = background_pointer_one;
    end else begin
      active_data_pointer_o = background_pointer_zero;
    end
  end
  assign pointer_select_o = pointer_select;

  // control view with reserved bits reading zero
  always_comb begin
    ctrl_view                       = 8'h00;
    ctrl_view[active_data_pointer_pkg::SELECT_BIT] = pointer_select;
    ctrl_view[active_data_pointer_pkg::TOGGLE_BIT] = auto_toggle;
  end

  // mode view, upper nibble reserved
  assign mode_view = {4'h0, mode_bits};

  // read mux; unmapped addresses answer zero with no hit
  always_comb begin
    next_rdata = 8'h00;
    next_hit   = 1'b0;
    if (rd_low) begin
      next_rdata = active_data_pointer_o[7:0];
      next_hit   = 1'b1;
    end else if (rd_high) begin
      next_rdata = active_data_pointer_o[15:8];
      next_hit   = 1'b1;
    end else if (rd_ctrl) begin
      next_rdata = ctrl_view;
      next_hit   = 1'b1;
    end else if (rd_mode) begin
      next_rdata = mode_view;
      next_hit   = 1'b1;
    end
  end

  // read data, registered, standing one cycle after the read strobe
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sfr_rdata_o <= 8'h00;
    end else begin
      sfr_rdata_o <= next_rdata;
    end
  end

  // read hit pulse, one cycle after a mapped read
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      sfr_hit_o <= 1'b0;
    end else begin
      sfr_hit_o <= next_hit;
    end
  end
endmodule

// ---- active_data_pointer_pkg.sv ----
// constants and carriers shared by the dual data pointer unit
package active_data_pointer_pkg;
  localparam logic [7:0] ADDR_PTR_LOW     = 8'h82;
  localparam logic [7:0] ADDR_PTR_HIGH    = 8'h83;
  localparam logic [7:0] ADDR_CONTROL     = 8'h85;
  localparam logic [7:0] ADDR_MODE        = 8'h86;
  localparam logic [7:0] CONTROL_RESET    = 8'h00;
  localparam logic [7:0] MODE_RESET       = 8'h00;
  localparam int         SELECT_BIT       = 0;
  localparam int         TOGGLE_BIT       = 6;
  localparam int         ZERO_MODE_LSB    = 0;
  localparam int         ONE_MODE_LSB     = 2;
  localparam int         PTR_WIDTH        = 16;
  localparam logic [15:0] PTR_RESET       = 16'h0000;

  typedef enum logic [1:0] {
    STEP_NONE     = 2'b00,
    STEP_RESERVED = 2'b01,
    STEP_INC      = 2'b10,
    STEP_DEC      = 2'b11
  } step_mode_type;

  // special-function bus request from the core
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_type;
endpackage

// ---- pointer_stepper.sv ----
// one background pointer: load bytes, hold, or step by mode
`timescale 1ns/1ps
module pointer_stepper #(
  parameter int WIDTH = 16
) (
  // clock and reset
  input  wire logic                   mclk_i,
  input  wire logic                   rst_i,
  // control
  input  wire logic                   load_low_i,
  input  wire logic                   load_high_i,
  input  wire logic [7:0]             load_data_i,
  input  wire logic                   step_i,
  input  wire active_data_pointer_pkg::step_mode_type mode_i,
  // value
  output logic      [WIDTH-1:0]       value_o
);
  // byte loads win over a step; stepping wraps silently
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      value_o <= WIDTH'(active_data_pointer_pkg::PTR_RESET);
    end else if (load_low_i) begin
      value_o[7:0] <= load_data_i;
    end else if (load_high_i) begin
      value_o[WIDTH-1:8] <= load_data_i[WIDTH-9:0];
    end else if (step_i) begin
      case (mode_i)
        active_data_pointer_pkg::STEP_INC: value_o <= value_o + WIDTH'(1);
        active_data_pointer_pkg::STEP_DEC: value_o <= value_o - WIDTH'(1);
        default:            value_o <= value_o;
      endcase
    end
  end
endmodule

// ---- dual_data_pointer_unit_props.sv ----
// port assertions for the dual data pointer unit
`timescale 1ns/1ps
module ptr_unit_checker (
  // clock and reset
  input wire logic                  mclk_i,
  input wire logic                  rst_i,
  // bus, move and pointer
  input wire active_data_pointer_pkg::sfr_req_type sfr_req_i,
  input wire logic [7:0]            sfr_rdata_o,
  input wire logic                  sfr_hit_o,
  input wire logic                  ext_move_done_i,
  input wire logic [15:0]           active_data_pointer_o,
  input wire logic                  pointer_select_o
);
  logic       rd;
  logic       cw;
  logic       at_on;
  logic [7:0] ad;
  logic [7:0] wd;
  logic [3:0] md;
  logic [15:0] stepped;
  // bus field shorthands
  assign rd = sfr_req_i.rd;
  assign ad = sfr_req_i.addr;
  assign wd = sfr_req_i.wdata;
  assign cw = sfr_req_i.wr && ad == 8'h85;
  // mirror of the auto toggle bit
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      at_on <= 1'b0;
    end else if (cw) begin
      at_on <= wd[6];
    end
  end
  // mirror of the mode register
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      md <= 4'h0;
    end else if (sfr_req_i.wr && ad == 8'h86) begin
      md <= wd[3:0];
    end
  end
  // active pointer after one step in its own mode
  always_comb begin
    stepped = active_data_pointer_o;
    case (pointer_select_o ? md[3:2] : md[1:0])
      2'b10:   stepped = active_data_pointer_o + 16'h0001;
      2'b11:   stepped = active_data_pointer_o - 16'h0001;
      default: stepped = active_data_pointer_o;
    endcase
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  hit_read_a: assert property (
    rd && ad inside {8'h82, 8'h83, 8'h85, 8'h86} |=> sfr_hit_o) else $error("hit missing");
  miss_read_a: assert property (
    rd && !(ad inside {8'h82, 8'h83, 8'h85, 8'h86}) |=> !sfr_hit_o && sfr_rdata_o == 8'h00)
    else $error("unmapped read answered");
  ctl_read_a: assert property (rd && ad == 8'h85 |=>
    sfr_rdata_o == {1'b0, $past(at_on), 5'h00, $past(pointer_select_o)}) else $error("bad control");
  sel_write_a: assert property (
    cw |=> pointer_select_o == $past(wd[0])) else $error("select not written");
  toggle_move_a: assert property (
    ext_move_done_i && at_on && !cw |=> pointer_select_o != $past(pointer_select_o))
    else $error("no toggle");
  sel_hold_a: assert property (
    !(ext_move_done_i && at_on) && !cw |=> $stable(pointer_select_o)) else $error("select moved");
  low_byte_a: assert property (
    sfr_req_i.wr && ad == 8'h82 && !ext_move_done_i |=> active_data_pointer_o[7:0] == $past(wd))
    else $error("low byte lost");
  ptr_still_a: assert property (
    !sfr_req_i.wr && !ext_move_done_i |=> $stable(active_data_pointer_o)) else $error("drift");
  move_step_a: assert property (
    ext_move_done_i && !at_on && !sfr_req_i.wr |=> active_data_pointer_o == $past(stepped))
    else $error("step wrong");
  read_quiet_a: assert property (
    !rd |=> !sfr_hit_o && sfr_rdata_o == 8'h00) else $error("stale read answer");
endmodule
bind dual_data_pointer_unit ptr_unit_checker u_props (.mclk_i(mclk_i), .rst_i(rst_i),
  .sfr_req_i(sfr_req_i), .sfr_rdata_o(sfr_rdata_o), .sfr_hit_o(sfr_hit_o),
  .ext_move_done_i(ext_move_done_i), .active_data_pointer_o(active_data_pointer_o),
  .pointer_select_o(pointer_select_o));

// ---- core_bus_model.sv ----
// core-side model issuing bus cycles and move strobes
`timescale 1ns/1ps
module core_bus_model (
  // clock
  input  wire logic             mclk_i,
  // requests and answer
  output active_data_pointer_pkg::sfr_req_type req_o,
  output logic                  done_o,
  input  wire logic [7:0]       rdata_i
);
  // idle bus at time zero
  initial begin
    req_o = '0;
    done_o = 1'b0;
  end
  // one access, read data taken a cycle later, idle fields inverted
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(negedge mclk_i);
    req_o = '{w, !w, a, d};
    @(negedge mclk_i);
    q = rdata_i;
    req_o = '{1'b0, 1'b0, ~a, ~d};
  endtask
  // one completed external move
  task automatic move();
    @(negedge mclk_i);
    done_o = 1'b1;
    @(negedge mclk_i);
    done_o = 1'b0;
  endtask
endmodule

// ---- dual_data_pointer_unit_test.sv ----
// self-checking bench for the dual data pointer unit
`timescale 1ns/1ps
module dual_data_pointer_unit_test;
  logic                  mclk_i = 1'b0;
  logic                  rst_i = 1'b1;
  active_data_pointer_pkg::sfr_req_type req;
  logic [7:0]            rdata;
  logic [7:0]            q;
  logic                  done;
  logic                  hit;
  logic                  sel;
  logic [15:0]           ptr;
  int                    fails = 0;
  int                    check_count = 0;
  always #2 mclk_i = ~mclk_i;
  dual_data_pointer_unit u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .sfr_req_i(req),
    .sfr_rdata_o(rdata), .sfr_hit_o(hit), .ext_move_done_i(done),
    .active_data_pointer_o(ptr), .pointer_select_o(sel));
  core_bus_model u_core (.mclk_i(mclk_i), .req_o(req), .done_o(done), .rdata_i(rdata));
  // compare and count
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    u_core.acc(1'b1, a, d, q);
  endtask
  task automatic r(input logic [7:0] a);
    u_core.acc(1'b0, a, 8'h00, q);
  endtask
  // reset values, selection and register access
  task automatic test_select();
    check({sel, ptr}, 17'h00000);
    r(8'h86);
    check(q, 8'h00);
    check(hit, 1'b1);
    w(8'h82, 8'hFF);
    w(8'h83, 8'hFF);
    w(8'h85, 8'hBF);
    r(8'h85);
    check(q, 8'h01);
    check(ptr, 16'h0000);
    w(8'h83, 8'hAB);
    w(8'h82, 8'hCD);
    r(8'h84);
    check(q, 8'h00);
    check(hit, 1'b0);
    $display("test_select done");
  endtask
  // stepping, wrap, toggle order and reserved mode
  task automatic test_step();
    w(8'h86, 8'h0E);
    w(8'h85, 8'h40);
    u_core.move();
    check({sel, ptr}, 17'h1ABCD);
    u_core.move();
    check({sel, ptr}, 17'h00000);
    w(8'h85, 8'h00);
    u_core.move();
    check({sel, ptr}, 17'h00001);
    w(8'h86, 8'h05);
    u_core.move();
    check({sel, ptr}, 17'h00001);
    w(8'h85, 8'h01);
    check({sel, ptr}, 17'h1ABCC);
    r(8'h83);
    check(q, 8'hAB);
    check(hit, 1'b1);
    $display("test_step done");
  endtask
  // verdict and end of run
  task automatic print_verdict();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // reset then scenarios
  initial begin
    repeat (8) @(negedge mclk_i);
    rst_i = 1'b0;
    test_select();
    test_step();
    print_verdict();
  end
  // watchdog for a hung run
  initial begin
    #20000;
    fails++;
    print_verdict();
  end
endmodule
